/* File: hw/pbs_cycle_decode.v */
// cycle control and byte-write decode of a pipelined burst sram
//
// Overview of operation
// - sleep low and a strobe with a chip select inactive gives a deselect cycle, unless it is a processor strobe with chip select one inactive.
// - all selects active: processor strobe, or controller strobe without write, begins read.
// - no start strobe, advance low, no write: continue read at next burst address.
// - no start strobe, advance high, no write: suspend read, keep the address.
// - no start strobe, advance high, write after a read: begin write at current address.
// - all selects, controller strobe only, write requested: begin write at external address.
// - no start strobe, advance low, write requested: continue write at next address.
// - no start strobe, advance high, write during a write: suspend write, hold address.
// - sleep high overrides every control input, no address, data pins float.
// - outside a processor strobe start, read or write decided only from global write, byte write enable, byte selects.
// - pin drivers gated by current cycle and output enable, which is never registered.
// - global write high with byte enable high or all byte selects high means read.
// - byte select n owns data bits 8n+7 down to 8n.
// - byte write writes exactly the lanes whose select is low.
// - global write low writes all four lanes.
// - two-bit burst counter steps linear or interleaved per burst order input.
// - processor strobe ignored while chip select one is inactive.
// - processor strobe access ignores write and advance inputs in its first cycle.
// - read data leaves one edge after address; first cycle out of deselect floats.
`default_nettype none
`include "pbs_consts.vh"

module pbs_cycle_decode #(
   parameter ADDR_W = 17
) (
   input  wire                   core_clk,
   input  wire                   sys_rst,
   input  wire                   sleep_in,
   input  wire                   chip_sel_one_n,
   input  wire                   chip_sel_two,
   input  wire                   chip_sel_three_n,
   input  wire                   proc_addr_strobe_n,
   input  wire                   ctrl_addr_strobe_n,
   input  wire                   burst_advance_n,
   input  wire                   global_write_n,
   input  wire                   byte_write_enable_n,
   input  wire [`PBS_LANES-1:0]  byte_select_n,
   input  wire                   out_enable_n,
   input  wire                   burst_linear,
   input  wire [ADDR_W-1:0]      addr_in,
   input  wire [`PBS_DATA_W-1:0] dq_in,
   input  wire [`PBS_DATA_W-1:0] mem_rd_data,
   output wire [ADDR_W-1:0]      mem_addr,
   output wire                   mem_rd_en,
   output reg  [`PBS_LANES-1:0]  mem_wr_lanes_q,
   output wire [`PBS_DATA_W-1:0] mem_wr_mask,
   output reg  [`PBS_DATA_W-1:0] mem_wr_data_q,
   output reg  [`PBS_DATA_W-1:0] dq_out_q,
   output wire                   dq_oe_n,
   output wire [`PBS_CLS_W-1:0]  cycle_class,
   output wire                   sleep_active
);

   localparam HI_W = ADDR_W - `PBS_OFS_W;

   reg  [`PBS_CLS_W-1:0] cls_q;
   reg  [`PBS_CLS_W-1:0] cls_d;
   reg  [HI_W-1:0]       addr_hi_q;
   reg                   sleep_s1_q;
   reg                   sleep_s2_q;
   reg                   idle_q;
   reg                   rd_pend_q;
   reg                   mask_q;
   reg                   all_sel;
   reg                   start_p;
   reg                   start_c;
   reg  [`PBS_LANES-1:0] wr_lanes;
   reg                   wr_req;
   wire                  ext_load;
   wire                  burst_step;
   wire [`PBS_OFS_W-1:0] burst_ofs;

   // lane enables from the write pins alone
   function [`PBS_LANES-1:0] lane_decode;
      input                  gw_n;
      input                  bwe_n;
      input [`PBS_LANES-1:0] sel_n;
      begin
         if (!gw_n) begin
            lane_decode = `PBS_LANES_ALL;
         end else if (bwe_n) begin
            lane_decode = `PBS_LANES_NONE;
         end else begin
            lane_decode = ~sel_n;
         end
      end
   endfunction

   // read-side classes
   function is_rd;
      input [`PBS_CLS_W-1:0] cls;
      begin
         is_rd = (cls == `PBS_CLS_BEG_RD) || (cls == `PBS_CLS_CONT_RD) ||
                 (cls == `PBS_CLS_SUSP_RD);
      end
   endfunction

   // write-side classes, including the suspended one
   function is_wr;
      input [`PBS_CLS_W-1:0] cls;
      begin
         is_wr = (cls == `PBS_CLS_BEG_WR_EXT) || (cls == `PBS_CLS_BEG_WR_CUR) ||
                 (cls == `PBS_CLS_CONT_WR) || (cls == `PBS_CLS_SUSP_WR);
      end
   endfunction

   // sleep is asynchronous, so it is synchronised before anything uses it
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sleep_s1_q <= `PBS_BIT_CLR;
         sleep_s2_q <= `PBS_BIT_CLR;
      end else begin
         sleep_s1_q <= sleep_in;
         sleep_s2_q <= sleep_s1_q;
      end
   end

   // next cycle class from the pins seen at this edge
   always @* begin
      all_sel  = ~chip_sel_one_n & chip_sel_two & ~chip_sel_three_n;
      start_p  = ~chip_sel_one_n & ~proc_addr_strobe_n;
      start_c  = ~ctrl_addr_strobe_n;
      wr_lanes = lane_decode(global_write_n, byte_write_enable_n, byte_select_n);
      wr_req   = |wr_lanes;
      cls_d    = `PBS_CLS_DESEL;
      if (sleep_s2_q) begin
         cls_d = `PBS_CLS_SLEEP;
      end else if (start_p || start_c) begin
         if (!all_sel) begin
            cls_d = `PBS_CLS_DESEL;
         end else if (start_p || !wr_req) begin
            cls_d = `PBS_CLS_BEG_RD;
         end else begin
            cls_d = `PBS_CLS_BEG_WR_EXT;
         end
      end else begin
         case (cls_q)
            `PBS_CLS_DESEL, `PBS_CLS_SLEEP: begin
               cls_d = `PBS_CLS_DESEL;   // nothing open to continue
            end
            default: begin
               if (!burst_advance_n) begin
                  cls_d = wr_req ? `PBS_CLS_CONT_WR : `PBS_CLS_CONT_RD;
               end else if (!wr_req) begin
                  cls_d = `PBS_CLS_SUSP_RD;
               end else if (is_wr(cls_q)) begin
                  cls_d = `PBS_CLS_SUSP_WR;
               end else begin
                  cls_d = `PBS_CLS_BEG_WR_CUR;
               end
            end
         endcase
      end
   end

   assign ext_load   = (cls_d == `PBS_CLS_BEG_RD) || (cls_d == `PBS_CLS_BEG_WR_EXT);
   assign burst_step = (cls_d == `PBS_CLS_CONT_RD) || (cls_d == `PBS_CLS_CONT_WR);

   // low address bits live in the burst counter
   pbs_burst_ctr u_burst (
      .core_clk     (core_clk),
      .sys_rst      (sys_rst),
      .load         (ext_load),
      .step         (burst_step),
      .base         (addr_in[`PBS_OFS_W-1:0]),
      .burst_linear (burst_linear),
      .offset_q     (burst_ofs)
   );

   // cycle, address and write registers; suspend and current keep the address
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cls_q          <= `PBS_CLS_DESEL;
         addr_hi_q      <= {HI_W{`PBS_BIT_CLR}};
         mem_wr_lanes_q <= `PBS_LANES_NONE;
         mem_wr_data_q  <= `PBS_DATA_RST;
      end else begin
         cls_q <= cls_d;
         if (ext_load) begin
            addr_hi_q <= addr_in[ADDR_W-1:`PBS_OFS_W];
         end
         // a processor-strobe first cycle is a read, so its lanes stay off
         mem_wr_lanes_q <= is_wr(cls_d) ? wr_lanes : `PBS_LANES_NONE;
         mem_wr_data_q  <= dq_in;
      end
   end

   // read pipeline: data registered one edge after its address
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         idle_q    <= `PBS_BIT_SET;
         rd_pend_q <= `PBS_BIT_CLR;
         mask_q    <= `PBS_BIT_CLR;
         dq_out_q  <= `PBS_DATA_RST;
      end else begin
         idle_q    <= (cls_q == `PBS_CLS_DESEL) || (cls_q == `PBS_CLS_SLEEP);
         rd_pend_q <= is_rd(cls_q);
         // hides the first data after deselect, as bank expansion needs
         mask_q    <= is_rd(cls_q) && idle_q;
         dq_out_q  <= mem_rd_data;
      end
   end

   // per-lane write mask, data byte and parity bit together
   genvar ln;
   generate
      for (ln = 0; ln < `PBS_LANES; ln = ln + 1) begin : g_lane
         assign mem_wr_mask[ln*`PBS_BYTE_W +: `PBS_BYTE_W] = {`PBS_BYTE_W{mem_wr_lanes_q[ln]}};
         assign mem_wr_mask[`PBS_PAR_BASE + ln] = mem_wr_lanes_q[ln];
      end
   endgenerate

   // output enable stays combinational; writes and deselect force float
   // drivers off in any write cycle even if the controller slips
   assign dq_oe_n = ~(rd_pend_q & ~mask_q & is_rd(cls_q) & ~out_enable_n);

   assign mem_addr     = {addr_hi_q, burst_ofs};
   assign mem_rd_en    = is_rd(cls_q);
   assign cycle_class  = cls_q;
   assign sleep_active = (cls_q == `PBS_CLS_SLEEP);

endmodule
`default_nettype wire

/* File: hw/pbs_consts.vh */
// shared constants for the pipelined burst sram cycle decode
`ifndef PBS_CONSTS_VH
`define PBS_CONSTS_VH

// cycle classes, binary coded
`define PBS_CLS_W          4
`define PBS_CLS_DESEL      4'h0
`define PBS_CLS_BEG_RD     4'h1
`define PBS_CLS_CONT_RD    4'h2
`define PBS_CLS_SUSP_RD    4'h3
`define PBS_CLS_BEG_WR_EXT 4'h4
`define PBS_CLS_BEG_WR_CUR 4'h5
`define PBS_CLS_CONT_WR    4'h6
`define PBS_CLS_SUSP_WR    4'h7
`define PBS_CLS_SLEEP      4'h8

// lane layout: data byte n on bits 8n+7..8n, its parity on bit 32+n
`define PBS_LANES          4
`define PBS_BYTE_W         8
`define PBS_PAR_BASE       32
`define PBS_DATA_W         36
`define PBS_LANES_NONE     4'h0
`define PBS_LANES_ALL      4'hF

// burst offset and reset values
`define PBS_OFS_W          2
`define PBS_OFS_RST        2'h0
`define PBS_OFS_STEP       2'h1
`define PBS_DATA_RST       36'h0
`define PBS_BIT_CLR        1'b0
`define PBS_BIT_SET        1'b1

`endif

/* File: hw/pbs_burst_ctr.v */
// two-bit wraparound burst counter, linear or interleaved order
`default_nettype none
`include "pbs_consts.vh"

module pbs_burst_ctr (
   input  wire                  core_clk,
   input  wire                  sys_rst,
   input  wire                  load,
   input  wire                  step,
   input  wire [`PBS_OFS_W-1:0] base,
   input  wire                  burst_linear,
   output reg  [`PBS_OFS_W-1:0] offset_q
);

   reg  [`PBS_OFS_W-1:0] base_q;
   reg  [`PBS_OFS_W-1:0] cnt_q;
   wire [`PBS_OFS_W-1:0] cnt_d;

   assign cnt_d = cnt_q + `PBS_OFS_STEP;

   // base and step count kept apart so both orders come from one counter
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         base_q   <= `PBS_OFS_RST;
         cnt_q    <= `PBS_OFS_RST;
         offset_q <= `PBS_OFS_RST;
      end else if (load) begin
         base_q   <= base;
         cnt_q    <= `PBS_OFS_RST;
         offset_q <= base;
      end else if (step) begin
         cnt_q <= cnt_d;
         // linear adds, interleaved xors; both wrap in two bits
         if (burst_linear) begin
            offset_q <= base_q + cnt_d;
         end else begin
            offset_q <= base_q ^ cnt_d;
         end
      end
   end

endmodule
`default_nettype wire

/* File: dv/pbs_cycle_chk_assertions.sv */
// port-level checks of the burst sram cycle decoder
`default_nettype none
module pbs_cycle_chk #(
   parameter ADDR_W = 17
) (
   input wire logic              core_clk,
   input wire logic              sys_rst,
   input wire logic              sleep_in,
   input wire logic              chip_sel_one_n,
   input wire logic              chip_sel_two,
   input wire logic              chip_sel_three_n,
   input wire logic              proc_addr_strobe_n,
   input wire logic              ctrl_addr_strobe_n,
   input wire logic              burst_advance_n,
   input wire logic              global_write_n,
   input wire logic              byte_write_enable_n,
   input wire logic [3:0]        byte_select_n,
   input wire logic              out_enable_n,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic [3:0]        mem_wr_lanes_q,
   input wire logic [35:0]       mem_wr_mask,
   input wire logic              dq_oe_n,
   input wire logic [3:0]        cycle_class,
   input wire logic              sleep_active
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // pin groups as seen at the sampling edge
   wire sel = !chip_sel_one_n && chip_sel_two && !chip_sel_three_n;
   wire wr = !global_write_n || (!byte_write_enable_n && byte_select_n != 4'hF);
   wire quiet = proc_addr_strobe_n && ctrl_addr_strobe_n;
   wire rd_open = cycle_class inside {4'h1, 4'h2, 4'h3};
   // sleep passes two flops, so three low samples make the class trustworthy
   sequence awake;
      !sleep_in [*3];
   endsequence
   a_desel_cycle: assert property (awake ##0 (chip_sel_one_n && !ctrl_addr_strobe_n)
      |=> cycle_class == 4'h0) else $error("deselect not taken");
   a_read_begin: assert property (awake ##0 (sel && !proc_addr_strobe_n)
      |=> cycle_class == 4'h1 && mem_wr_lanes_q == 4'h0 && mem_addr == $past(addr_in))
      else $error("begin read wrong");
   a_write_ext: assert property (awake ##0 (sel && quiet == 0 && proc_addr_strobe_n && wr)
      |=> cycle_class == 4'h4 && mem_wr_lanes_q == ($past(global_write_n) ?
      ~$past(byte_select_n) : 4'hF)) else $error("external write wrong");
   a_proc_ignore: assert property (chip_sel_one_n && ctrl_addr_strobe_n
      |=> !(cycle_class inside {4'h1, 4'h4})) else $error("strobe not ignored");
   a_read_cont: assert property (awake ##0 (rd_open && quiet && !burst_advance_n && !wr)
      |=> cycle_class == 4'h2 && mem_wr_lanes_q == 4'h0) else $error("continue read wrong");
   a_write_cur: assert property (awake ##0 (rd_open && quiet && burst_advance_n && wr)
      |=> cycle_class == 4'h5 && mem_addr == $past(mem_addr)) else $error("write current wrong");
   a_sleep_entry: assert property (sleep_in [*4] |=> sleep_active)
      else $error("sleep not entered");
   a_sleep_float: assert property ((sleep_active == (cycle_class == 4'h8))
      && (!sleep_active || dq_oe_n)) else $error("sleep state wrong");
   a_write_float: assert property (cycle_class inside {4'h0, [4'h4:4'h8]}
      |-> dq_oe_n) else $error("pins driven outside read");
   a_oe_gate: assert property (out_enable_n |-> dq_oe_n)
      else $error("driving without output enable");
   a_mask_map: assert property (mem_wr_mask == {mem_wr_lanes_q, {8{mem_wr_lanes_q[3]}},
      {8{mem_wr_lanes_q[2]}}, {8{mem_wr_lanes_q[1]}}, {8{mem_wr_lanes_q[0]}}})
      else $error("lane mask wrong");
endmodule
bind pbs_cycle_decode pbs_cycle_chk #(.ADDR_W(ADDR_W)) pbs_cycle_chk_i (
   .core_clk, .sys_rst, .sleep_in, .chip_sel_one_n, .chip_sel_two, .chip_sel_three_n,
   .proc_addr_strobe_n, .ctrl_addr_strobe_n, .burst_advance_n, .global_write_n,
   .byte_write_enable_n, .byte_select_n, .out_enable_n, .addr_in, .mem_addr,
   .mem_wr_lanes_q, .mem_wr_mask, .dq_oe_n, .cycle_class, .sleep_active);
`default_nettype wire

/* File: dv/pbs_mem_model.sv */
// small array model behind the cycle decoder, 64 words
`default_nettype none
module pbs_mem_model (
   input  wire logic        core_clk,
   input  wire logic [16:0] mem_addr,
   input  wire logic        mem_rd_en,
   input  wire logic [3:0]  mem_wr_lanes_q,
   input  wire logic [35:0] mem_wr_mask,
   input  wire logic [35:0] mem_wr_data_q,
   output logic      [35:0] mem_rd_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [35:0] mem_q [0:63];
   initial for (int i = 0; i < 64; i++) mem_q[i] = 36'h0;
   // inverted data outside reads, so a stale capture cannot pass
   assign mem_rd_data = mem_rd_en ? mem_q[mem_addr[5:0]] : ~mem_q[mem_addr[5:0]];
   // lanes outside the mask keep their old bytes and parity
   always @(posedge core_clk) begin
      if (mem_wr_lanes_q != 4'h0)
         mem_q[mem_addr[5:0]] <= (mem_q[mem_addr[5:0]] & ~mem_wr_mask)
            | (mem_wr_data_q & mem_wr_mask);
   end
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for the burst sram cycle decoder
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, sys_rst, sleep_in, chip_sel_one_n, chip_sel_two, chip_sel_three_n;
   logic proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n, global_write_n;
   logic byte_write_enable_n, out_enable_n, burst_linear, mem_rd_en, dq_oe_n, sleep_active;
   logic [3:0]  byte_select_n, mem_wr_lanes_q, cycle_class;
   logic [16:0] addr_in, mem_addr;
   logic [35:0] dq_in, mem_rd_data, mem_wr_mask, mem_wr_data_q, dq_out_q, exp_q;
   logic [7:0]  desel_tab [4] = '{8'hD7, 8'hCF, 8'h6F, 8'h17};
   int          num_errors = 0;
   int          num_checks = 0;
   pbs_cycle_decode #(.ADDR_W(17)) pbs_cycle_decode_i (.core_clk, .sys_rst, .sleep_in,
      .chip_sel_one_n, .chip_sel_two, .chip_sel_three_n, .proc_addr_strobe_n,
      .ctrl_addr_strobe_n, .burst_advance_n, .global_write_n, .byte_write_enable_n,
      .byte_select_n, .out_enable_n, .burst_linear, .addr_in, .dq_in, .mem_rd_data,
      .mem_addr, .mem_rd_en, .mem_wr_lanes_q, .mem_wr_mask, .mem_wr_data_q, .dq_out_q,
      .dq_oe_n, .cycle_class, .sleep_active);
   pbs_mem_model pbs_mem_model_i (.core_clk, .mem_addr, .mem_rd_en, .mem_wr_lanes_q,
      .mem_wr_mask, .mem_wr_data_q, .mem_rd_data);
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // pins {cs1, cs2, cs3, proc, ctrl, adv, gw, bwe}, then one clock
   task step(input logic [7:0] c, input logic [3:0] b);
      {chip_sel_one_n, chip_sel_two, chip_sel_three_n, proc_addr_strobe_n, ctrl_addr_strobe_n,
         burst_advance_n, global_write_n, byte_write_enable_n} = c;
      byte_select_n = b;
      @(negedge core_clk);
   endtask
   task eq(input logic [35:0] got, input logic [35:0] want);
      num_checks++;
      if (got !== want) begin
         num_errors++;
         $display("[FAIL] %0t ns: got %h want %h", $time, got, want);
      end
   endtask
   function automatic logic [35:0] lm(input logic [3:0] l);
      lm = 36'h0;
      for (int i = 0; i < 4; i++) begin
         lm[8*i +: 8] = {8{l[i]}};
         lm[32+i] = l[i];
      end
   endfunction
   // open a read from deselect and walk three burst steps
   task burst(input logic lin, input logic [1:0] base);
      logic [1:0] o;
      burst_linear = lin;
      addr_in = {15'h0021, base};
      step(8'hD7, 4'hF);
      step(8'h57, 4'hF);
      for (int k = 1; k < 4; k++) begin
         o = lin ? base + k[1:0] : base ^ k[1:0];
         step(8'h5B, 4'hF);
         eq(mem_addr, {15'h0021, o});
      end
   endtask
   task close_out;
      if (num_errors == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      {sys_rst, sleep_in, out_enable_n, burst_linear} = 4'hB;
      {addr_in, dq_in, exp_q} = '0;
      step(8'h5F, 4'hF);
      repeat (5) @(negedge core_clk);
      eq({cycle_class, mem_wr_lanes_q, dq_oe_n, mem_addr}, 36'h000020000);
      sys_rst = 1'b0;
      for (int i = 0; i < 4; i++) begin
         step(desel_tab[i], 4'hF);
         eq(cycle_class, 4'h0);
      end
      addr_in = 17'h00084;
      dq_in = 36'h912345678;
      exp_q = dq_in;
      out_enable_n = 1'b1;
      step(8'h54, 4'h5);
      eq({cycle_class, mem_wr_lanes_q}, 8'h4F);
      for (int b = 0; b < 16; b++) begin
         dq_in = {9{b[3:0]}};
         step(8'h56, b[3:0]);
         eq(cycle_class, b == 15 ? 4'h1 : 4'h4);
         eq(mem_wr_mask, lm(~b[3:0]));
         exp_q = (exp_q & ~lm(~b[3:0])) | (dq_in & lm(~b[3:0]));
      end
      step(8'hD7, 4'hF);
      out_enable_n = 1'b0;
      step(8'h57, 4'hF);
      eq({cycle_class, mem_addr}, {4'h1, 17'h00084});
      step(8'h5B, 4'hF);
      eq({dq_oe_n, cycle_class}, {1'b1, 4'h2});
      eq(dq_out_q, exp_q);
      step(8'h5F, 4'hF);
      eq({dq_oe_n, cycle_class, mem_addr}, {1'b0, 4'h3, 17'h00085});
      out_enable_n = 1'b1;
      #1 eq(dq_oe_n, 1'b1);
      out_enable_n = 1'b0;
      step(8'h5D, 4'hF);
      eq({dq_oe_n, cycle_class, mem_addr}, {1'b1, 4'h5, 17'h00085});
      step(8'h59, 4'hF);
      eq({dq_oe_n, cycle_class, mem_addr}, {1'b1, 4'h6, 17'h00086});
      step(8'h5D, 4'hF);
      eq({dq_oe_n, cycle_class, mem_addr}, {1'b1, 4'h7, 17'h00086});
      addr_in = 17'h00093;
      step(8'h4C, 4'h0);
      eq({cycle_class, mem_wr_lanes_q}, 8'h10);
      step(8'h5D, 4'hF);
      eq({cycle_class, mem_wr_lanes_q, mem_addr}, {8'h5F, 17'h00093});
      burst(1'b1, 2'h1);
      burst(1'b0, 2'h1);
      step(8'hD7, 4'hF);
      sleep_in = 1'b1;
      repeat (4) step(8'h5F, 4'hF);
      step(8'h57, 4'hF);
      eq({cycle_class, sleep_active, dq_oe_n}, 6'h23);
      sleep_in = 1'b0;
      repeat (3) step(8'h5F, 4'hF);
      eq(cycle_class, 4'h0);
      close_out();
   end
endmodule
`default_nettype wire
